// *** verilog/serial_access_defs.vh ***
// constants shared by the serial register access slave and its i2c engine
// assumes inclusion by bare name from files in the same folder
`ifndef SERIAL_ACCESS_DEFS_VH
`define SERIAL_ACCESS_DEFS_VH

// ****************************************
// management port mode straps
// ****************************************
`define MODE_SPI        2'h0
`define MODE_I2C        2'h1
`define MODE_PHY        2'h2

// ****************************************
// spi framing
// ****************************************
`define SPI_CMD_BITS    6'h1B
`define SPI_HDR_BITS    6'h20
`define SPI_CMD_READ    3'h3
`define SPI_CMD_WRITE   3'h2
`define SPI_LAST_BIT    3'h7

// ****************************************
// i2c framing
// ****************************************
`define I2C_DEV_ADDR    7'h5F
`define I2C_ACK_BIT     4'h8
`define I2C_ACK_END     4'h9

// ****************************************
// register space
// ****************************************
`define REG_ADDR_W      16
`define REG_DATA_W      8

`endif

// *** verilog/i2c_slave_engine.v ***
// i2c slave byte engine: fixed device address, 16-bit pointer, byte data
// assumes scl and sda already pass two flip-flops in the parent
`timescale 1ns/10ps
`include "serial_access_defs.vh"

module i2c_slave_engine (
    input  wire        i_clk,
    input  wire        i_rst_b,
    input  wire        i_enable,
    input  wire        i_scl,
    input  wire        i_sda,
    input  wire [7:0]  i_rdata,
    input  wire        i_rdata_valid,
    output reg         o_sda_oe,
    output reg  [15:0] o_addr,
    output reg  [7:0]  o_wdata,
    output reg         o_wr,
    output reg         o_rd
);

    // ****************************************
    // states
    // ****************************************
    localparam [5:0] ST_IDLE = 6'h01;
    localparam [5:0] ST_DEV  = 6'h02;
    localparam [5:0] ST_AH   = 6'h04;
    localparam [5:0] ST_AL   = 6'h08;
    localparam [5:0] ST_WR   = 6'h10;
    localparam [5:0] ST_RD   = 6'h20;

    reg [5:0] state_reg;
    reg [3:0] bit_cnt_reg;
    reg [7:0] rx_reg;
    reg [7:0] tx_reg;
    reg       scl_d_reg;
    reg       sda_d_reg;
    reg       nack_reg;

    wire scl_rise = i_scl & ~scl_d_reg;
    wire scl_fall = ~i_scl & scl_d_reg;
    wire start    = i_scl & scl_d_reg & sda_d_reg & ~i_sda;
    wire stop     = i_scl & scl_d_reg & ~sda_d_reg & i_sda;
    wire dev_hit  = (rx_reg[7:1] == `I2C_DEV_ADDR);

    // ****************************************
    // byte sequencing
    // ****************************************
    always @(posedge i_clk) begin
        scl_d_reg <= i_scl;
        sda_d_reg <= i_sda;
        o_wr      <= 1'b0;
        o_rd      <= 1'b0;
        if (!i_rst_b || !i_enable) begin
            state_reg   <= ST_IDLE;
            bit_cnt_reg <= 4'h0;
            rx_reg      <= 8'h00;
            tx_reg      <= 8'h00;
            nack_reg    <= 1'b0;
            o_sda_oe    <= 1'b0;
            o_addr      <= 16'h0000;
            o_wdata     <= 8'h00;
        end else if (start) begin
            // repeated start keeps the pointer
            state_reg   <= ST_DEV;
            nack_reg    <= 1'b0;
            bit_cnt_reg <= 4'h0;
            o_sda_oe    <= 1'b0;
        end else if (stop) begin
            state_reg   <= ST_IDLE;
            o_sda_oe    <= 1'b0;
        end else begin
            if (i_rdata_valid) begin
                tx_reg <= i_rdata;
            end
            if (scl_rise && state_reg != ST_IDLE) begin
                if (bit_cnt_reg < `I2C_ACK_BIT) begin
                    rx_reg      <= {rx_reg[6:0], i_sda};
                    bit_cnt_reg <= bit_cnt_reg + 4'h1;
                end else if (bit_cnt_reg == `I2C_ACK_BIT) begin
                    bit_cnt_reg <= `I2C_ACK_END;
                    // own address ack is not a master ack: no extra read there
                    if (state_reg == ST_RD && !o_sda_oe) begin
                        nack_reg <= i_sda;
                        if (!i_sda) begin
                            o_rd   <= 1'b1;
                            o_addr <= o_addr + 16'h0001;
                        end
                    end
                end
            end else if (scl_fall && state_reg != ST_IDLE) begin
                if (bit_cnt_reg == `I2C_ACK_BIT) begin
                    case (state_reg)
                        ST_DEV: begin
                            if (dev_hit) begin
                                o_sda_oe <= 1'b1;
                                // r/w flag is the lsb
                                if (rx_reg[0]) begin
                                    state_reg <= ST_RD;
                                    o_rd      <= 1'b1;
                                end else begin
                                    state_reg <= ST_AH;
                                end
                            end else begin
                                state_reg <= ST_IDLE;
                            end
                        end
                        ST_AH: begin
                            o_addr[15:8] <= rx_reg;
                            o_sda_oe     <= 1'b1;
                            state_reg    <= ST_AL;
                        end
                        ST_AL: begin
                            o_addr[7:0]  <= rx_reg;
                            o_sda_oe     <= 1'b1;
                            state_reg    <= ST_WR;
                        end
                        ST_WR: begin
                            o_wdata  <= rx_reg;
                            o_wr     <= 1'b1;
                            o_sda_oe <= 1'b1;
                        end
                        ST_RD: begin
                            o_sda_oe <= 1'b0;
                        end
                        default: begin
                            state_reg <= ST_IDLE;
                        end
                    endcase
                end else if (bit_cnt_reg == `I2C_ACK_END) begin
                    bit_cnt_reg <= 4'h0;
                    o_sda_oe    <= 1'b0;
                    if (state_reg == ST_RD) begin
                        if (nack_reg) begin
                            state_reg <= ST_IDLE;
                        end else begin
                            o_sda_oe <= ~tx_reg[7];
                        end
                    end
                end else if (state_reg == ST_RD) begin
                    o_sda_oe <= ~tx_reg[3'h7 - bit_cnt_reg[2:0]];
                end
            end
            // write pointer advances once the byte is handed on
            if (o_wr) begin
                o_addr <= o_addr + 16'h0001;
            end
        end
    end

endmodule // i2c_slave_engine

// *** verilog/serial_register_access_slave.v ***
// serial management port: spi or i2c slave onto a byte-wide register space
// assumes the register space answers i_reg_rdata in the cycle o_reg_rd is high
//
// How it works
// - mode strap caught on first clock after reset release, held until reset.
// - phy management mode opens no path to the switch registers.
// - master drives clock, select and input; only this block drives output.
// - select low starts an operation; select high drops all partial state.
// - 27 command/address bits, 5 turnaround bits, then 8 data bits.
// - burst keeps select low; every 8 clocks the address advances.
// - command, address and data shift most significant bit first.
// - input sampled on rising clock, output changed on falling clock.
// - command 011 reads, 010 writes; other codes are ignored.
// - input line ignored during the five turnaround bits.
// - only low 16 address bits decoded; bits 23 to 16 ignored.
// - i2c master may read and write every register location.
// - i2c answers only the fixed 7-bit address 1011111.
// - i2c read/write flag is the lsb after the address.
// - i2c carries a two-byte register address then byte data.
`timescale 1ns/10ps
`include "serial_access_defs.vh"

module serial_register_access_slave (
    input  wire        i_clk,
    input  wire        i_rst_b,
    input  wire [1:0]  i_mode_strap,
    input  wire        i_spi_clk,
    input  wire        i_select_active_low,
    input  wire        i_serial_in_line,
    input  wire        i_i2c_scl,
    input  wire        i_i2c_sda,
    input  wire [7:0]  i_reg_rdata,
    output wire        o_i2c_sda_oe,
    output reg         o_serial_out_line,
    output reg         o_serial_out_oe,
    output reg  [1:0]  o_mode,
    output reg         o_phy_management_mode,
    output reg  [15:0] o_reg_addr,
    output reg  [7:0]  o_reg_wdata,
    output reg         o_reg_wr,
    output reg         o_reg_rd
);

    // ****************************************
    // pin synchronisers
    // ****************************************
    reg [1:0] strap_s1_reg;
    reg [1:0] strap_s2_reg;
    reg       sclk_s1_reg;
    reg       sclk_s2_reg;
    reg       sclk_s3_reg;
    reg       cs_s1_reg;
    reg       cs_s2_reg;
    reg       sdi_s1_reg;
    reg       sdi_s2_reg;
    reg       scl_s1_reg;
    reg       scl_s2_reg;
    reg       sda_s1_reg;
    reg       sda_s2_reg;

    // pins carry no reset; they only feed the capture and edge logic
    always @(posedge i_clk) begin
        strap_s1_reg <= i_mode_strap;
        strap_s2_reg <= strap_s1_reg;
        sclk_s1_reg  <= i_spi_clk;
        sclk_s2_reg  <= sclk_s1_reg;
        sclk_s3_reg  <= sclk_s2_reg;
        cs_s1_reg    <= i_select_active_low;
        cs_s2_reg    <= cs_s1_reg;
        sdi_s1_reg   <= i_serial_in_line;
        sdi_s2_reg   <= sdi_s1_reg;
        scl_s1_reg   <= i_i2c_scl;
        scl_s2_reg   <= scl_s1_reg;
        sda_s1_reg   <= i_i2c_sda;
        sda_s2_reg   <= sda_s1_reg;
    end

    // ****************************************
    // mode capture
    // ****************************************
    reg mode_valid_reg;

    always @(posedge i_clk) begin
        if (!i_rst_b) begin
            mode_valid_reg        <= 1'b0;
            o_mode                <= `MODE_SPI;
            o_phy_management_mode <= 1'b0;
        end else if (!mode_valid_reg) begin
            // caught once after release, frozen until the next reset
            mode_valid_reg        <= 1'b1;
            o_mode                <= strap_s2_reg;
            o_phy_management_mode <= (strap_s2_reg == `MODE_PHY);
        end
    end

    wire spi_mode = mode_valid_reg & (o_mode == `MODE_SPI);
    wire i2c_mode = mode_valid_reg & (o_mode == `MODE_I2C);

    // ****************************************
    // spi framing
    // ****************************************
    reg [5:0]  hdr_cnt_reg;
    reg [25:0] hdr_reg;
    reg [2:0]  cmd_reg;
    reg [15:0] spi_addr_reg;
    reg [2:0]  dbit_reg;
    reg [6:0]  wshift_reg;
    reg [7:0]  spi_wdata_reg;
    reg [7:0]  tx_reg;
    reg        spi_wr_req_reg;
    reg        spi_rd_req_reg;

    // clock is idle low, so a rising edge always marks a real bit
    wire sclk_rise  = sclk_s2_reg & ~sclk_s3_reg;
    wire sclk_fall  = ~sclk_s2_reg & sclk_s3_reg;
    wire spi_active = spi_mode & ~cs_s2_reg;
    wire data_phase = (hdr_cnt_reg == `SPI_HDR_BITS);
    wire cmd_read   = (cmd_reg == `SPI_CMD_READ);
    wire cmd_write  = (cmd_reg == `SPI_CMD_WRITE);
    wire hdr_last   = (hdr_cnt_reg == `SPI_CMD_BITS - 6'h01);

    always @(posedge i_clk) begin
        spi_wr_req_reg <= 1'b0;
        spi_rd_req_reg <= 1'b0;
        if (!i_rst_b || !spi_active) begin
            // select high discards any partial operation
            hdr_cnt_reg   <= 6'h00;
            hdr_reg       <= 26'h0000000;
            cmd_reg       <= 3'h0;
            spi_addr_reg  <= 16'h0000;
            dbit_reg      <= 3'h0;
            wshift_reg    <= 7'h00;
            spi_wdata_reg <= 8'h00;
        end else begin
            if (sclk_rise) begin
                if (hdr_cnt_reg < `SPI_CMD_BITS) begin
                    // msb first into the header
                    hdr_reg     <= {hdr_reg[24:0], sdi_s2_reg};
                    hdr_cnt_reg <= hdr_cnt_reg + 6'h01;
                    if (hdr_last) begin
                        cmd_reg      <= hdr_reg[25:23];
                        // address bits 23..16 are dropped
                        spi_addr_reg <= {hdr_reg[14:0], sdi_s2_reg};
                        spi_rd_req_reg <= (hdr_reg[25:23] == `SPI_CMD_READ);
                    end
                end else if (!data_phase) begin
                    // turnaround bits counted but never looked at
                    hdr_cnt_reg <= hdr_cnt_reg + 6'h01;
                end else begin
                    dbit_reg   <= dbit_reg + 3'h1;
                    wshift_reg <= {wshift_reg[5:0], sdi_s2_reg};
                    if (dbit_reg == `SPI_LAST_BIT) begin
                        if (cmd_write) begin
                            spi_wdata_reg  <= {wshift_reg, sdi_s2_reg};
                            spi_wr_req_reg <= 1'b1;
                        end else if (cmd_read) begin
                            // prefetch the next byte of the burst
                            spi_addr_reg   <= spi_addr_reg + 16'h0001;
                            spi_rd_req_reg <= 1'b1;
                        end
                    end
                end
            end
            // write address steps only after the request has been taken
            if (spi_wr_req_reg) begin
                spi_addr_reg <= spi_addr_reg + 16'h0001;
            end
        end
    end

    // ****************************************
    // spi output line
    // ****************************************
    always @(posedge i_clk) begin
        if (!i_rst_b) begin
            tx_reg            <= 8'h00;
            o_serial_out_line <= 1'b0;
            o_serial_out_oe   <= 1'b0;
        end else begin
            if (o_reg_rd && spi_mode) begin
                tx_reg <= i_reg_rdata;
            end
            if (!spi_active || !cmd_read || !data_phase) begin
                // released when deselected or writing
                o_serial_out_oe <= 1'b0;
            end else if (sclk_fall) begin
                // only this block drives the output line
                o_serial_out_oe   <= 1'b1;
                o_serial_out_line <= tx_reg[3'h7 - dbit_reg];
            end
        end
    end

    // ****************************************
    // i2c engine
    // ****************************************
    wire [15:0] i2c_addr;
    wire [7:0]  i2c_wdata;
    wire        i2c_wr;
    wire        i2c_rd;

    i2c_slave_engine u_i2c (
        .i_clk         (i_clk),
        .i_rst_b       (i_rst_b),
        .i_enable      (i2c_mode),
        .i_scl         (scl_s2_reg),
        .i_sda         (sda_s2_reg),
        .i_rdata       (i_reg_rdata),
        .i_rdata_valid (o_reg_rd & i2c_mode),
        .o_sda_oe      (o_i2c_sda_oe),
        .o_addr        (i2c_addr),
        .o_wdata       (i2c_wdata),
        .o_wr          (i2c_wr),
        .o_rd          (i2c_rd)
    );

    // ****************************************
    // register port
    // ****************************************
    always @(posedge i_clk) begin
        o_reg_wr <= 1'b0;
        o_reg_rd <= 1'b0;
        if (!i_rst_b) begin
            o_reg_addr  <= 16'h0000;
            o_reg_wdata <= 8'h00;
        end else if (spi_mode) begin
            if (spi_wr_req_reg || spi_rd_req_reg) begin
                o_reg_addr  <= spi_addr_reg;
                o_reg_wdata <= spi_wdata_reg;
                o_reg_wr    <= spi_wr_req_reg;
                o_reg_rd    <= spi_rd_req_reg;
            end
        end else if (i2c_mode) begin
            // full register space reachable over i2c
            if (i2c_wr || i2c_rd) begin
                o_reg_addr  <= i2c_addr;
                o_reg_wdata <= i2c_wdata;
                o_reg_wr    <= i2c_wr;
                o_reg_rd    <= i2c_rd;
            end
        end
        // phy management mode leaves the port silent
    end

endmodule // serial_register_access_slave

// *** sim/serial_access_assertions.sv ***
// concurrent checks on the serial register access slave ports
// assumes the defs header is reachable by bare name; bound below
`timescale 1ns/10ps
`include "serial_access_defs.vh"

module serial_access_assertions (
    input wire logic        i_clk,
    input wire logic        i_rst_b,
    input wire logic        i_spi_clk,
    input wire logic        i_select_active_low,
    input wire logic        o_serial_out_line,
    input wire logic        o_serial_out_oe,
    input wire logic [1:0]  o_mode,
    input wire logic        o_phy_management_mode,
    input wire logic [15:0] o_reg_addr,
    input wire logic        o_reg_wr,
    input wire logic        o_reg_rd
);
    // ****************************************
    // frame bookkeeping
    // ****************************************
    // counts pin rises; the slave lags by its synchronisers, well inside a bit
    logic [5:0]  rise_cnt_reg;
    logic        step_ok_reg;
    logic [15:0] last_addr_reg;
    wire         spi_on = (o_mode == `MODE_SPI);
    wire         access = o_reg_wr || o_reg_rd;

    always @(posedge i_clk) begin
        if (!i_rst_b || i_select_active_low) begin
            rise_cnt_reg <= 6'h00;
            step_ok_reg  <= 1'b0;
        end else begin
            if ($rose(i_spi_clk) && rise_cnt_reg != 6'h3F)
                rise_cnt_reg <= rise_cnt_reg + 6'h01;
            if (access)
                step_ok_reg <= 1'b1;
        end
        if (access)
            last_addr_reg <= o_reg_addr;
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);

    sequence s_cs_idle;
        i_select_active_low [*6];
    endsequence
    sequence s_settled;
        $past(i_rst_b, 1) && $past(i_rst_b, 2) && $past(i_rst_b, 3);
    endsequence

    property p_mode_held;
        s_settled |-> $stable(o_mode) && $stable(o_phy_management_mode);
    endproperty
    property p_phy_silent;
        o_phy_management_mode |-> !access && o_mode == `MODE_PHY;
    endproperty
    property p_out_idle;
        s_cs_idle |-> !o_serial_out_oe;
    endproperty
    property p_wr_no_drive;
        o_reg_wr |-> !o_serial_out_oe;
    endproperty
    property p_out_on_fall;
        $changed(o_serial_out_line) |-> !$past(i_spi_clk, 1) && !$past(i_spi_clk, 2);
    endproperty
    property p_burst_step;
        spi_on && access && step_ok_reg |-> o_reg_addr == last_addr_reg + 16'h0001;
    endproperty
    property p_wr_slot;
        spi_on && o_reg_wr |-> rise_cnt_reg >= 6'h28 && rise_cnt_reg[2:0] == 3'h0;
    endproperty
    property p_rd_slot;
        spi_on && o_reg_rd |->
            rise_cnt_reg == 6'h1B || (rise_cnt_reg >= 6'h28 && rise_cnt_reg[2:0] == 3'h0);
    endproperty
    property p_abort_quiet;
        spi_on throughout s_cs_idle |-> !access;
    endproperty
    property p_one_access;
        access |-> !(o_reg_wr && o_reg_rd) ##1 !access;
    endproperty

    a_mode_held: assert property (p_mode_held) else $error("mode moved after reset");
    a_phy_silent: assert property (p_phy_silent) else $error("access in phy mode");
    a_out_idle: assert property (p_out_idle) else $error("out driven while idle");
    a_wr_no_drive: assert property (p_wr_no_drive) else $error("out driven on write");
    a_out_on_fall: assert property (p_out_on_fall) else $error("out moved off fall");
    a_burst_step: assert property (p_burst_step) else $error("burst address step");
    a_wr_slot: assert property (p_wr_slot) else $error("write off byte slot");
    a_rd_slot: assert property (p_rd_slot) else $error("read off byte slot");
    a_abort_quiet: assert property (p_abort_quiet) else $error("access while idle");
    a_one_access: assert property (p_one_access) else $error("access pulse shape");
endmodule // serial_access_assertions

bind serial_register_access_slave serial_access_assertions u_chk (
    .i_clk, .i_rst_b, .i_spi_clk, .i_select_active_low, .o_serial_out_line,
    .o_serial_out_oe, .o_mode, .o_phy_management_mode, .o_reg_addr, .o_reg_wr,
    .o_reg_rd
);

// *** sim/spi_host_model.sv ***
// spi master model facing the serial register access slave
// assumes a 100 ns system clock; link clock is 8 system cycles
`timescale 1ns/10ps

module spi_host_model (
    input  wire logic i_clk,
    input  wire logic i_sdo,
    output logic      o_sclk,
    output logic      o_cs_b,
    output logic      o_sdi
);
    localparam int HALF = 4;
    logic [23:0] rx_reg;

    initial begin
        o_sclk = 1'b0;
        o_cs_b = 1'b1;
        o_sdi  = 1'b0;
        rx_reg = 24'h000000;
    end

    // junk bits toggle so any leak into the slave shows
    task automatic send(input logic [39:0] v, input int n, input logic junk);
        for (int i = n - 1; i >= 0; i--) begin
            o_sdi <= junk ? ~o_sdi : v[i];
            repeat (HALF) @(posedge i_clk);
            o_sclk <= 1'b1;
            rx_reg <= {rx_reg[22:0], i_sdo};
            repeat (HALF) @(posedge i_clk);
            o_sclk <= 1'b0;
        end
    endtask

    task automatic frame(input logic [2:0] cmd, input logic [23:0] addr,
                         input logic [23:0] wd, input int n_bits);
        o_cs_b <= 1'b0;
        repeat (HALF) @(posedge i_clk);
        send({13'h0000, cmd, addr}, 27, 1'b0);
        send(40'h0, 5, 1'b1);
        send({16'h0000, wd}, n_bits, 1'b0);
        repeat (HALF) @(posedge i_clk);
        o_cs_b <= 1'b1;
        o_sdi  <= ~o_sdi;
        repeat (HALF) @(posedge i_clk);
    endtask
endmodule // spi_host_model

// *** sim/tb.sv ***
// self-checking bench for the serial register access slave
// assumes the defs header on the include path and the spi host model
`timescale 1ns/10ps
`include "serial_access_defs.vh"

`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin miscompares++; \
    $display("Error t=%0t got=%h exp=%h", $time, (got), (exp)); end end

module tb;
    logic        i_clk = 1'b0;
    logic        i_rst_b = 1'b0;
    logic [1:0]  i_mode_strap = 2'h0;
    logic        scl_reg = 1'b1;
    logic        sda_reg = 1'b1;
    wire         sclk, cs_b, serial_in_line, sda_wire, sda_oe, out_line, out_oe, phy_mode;
    wire         reg_wr, reg_rd;
    wire  [1:0]  mode;
    wire  [15:0] reg_addr;
    wire  [7:0]  reg_wdata, reg_rdata;
    logic [23:0] notes[$];
    logic [23:0] exp_note;
    logic [31:0] r;
    logic [7:0]  rx_byte = 8'h00;
    logic        oe_seen = 1'b0;
    int          miscompares = 0;
    int          n_checks = 0;
    int          cycles = 0;

    // register space stand-in: data is a fixed mix of the address
    function automatic logic [7:0] rdat(input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'hC3;
    endfunction

    always #50 i_clk = ~i_clk;
    assign sda_wire = sda_reg && (sda_oe !== 1'b1);
    assign reg_rdata = (reg_rd === 1'b1) ? rdat(reg_addr) : 8'h00;

    spi_host_model host (.i_clk(i_clk), .i_sdo(out_line), .o_sclk(sclk), .o_cs_b(cs_b),
        .o_sdi(serial_in_line));
    serial_register_access_slave DUT (.i_clk(i_clk), .i_rst_b(i_rst_b),
        .i_mode_strap(i_mode_strap), .i_spi_clk(sclk), .i_select_active_low(cs_b),
        .i_serial_in_line(serial_in_line), .i_i2c_scl(scl_reg), .i_i2c_sda(sda_wire),
        .i_reg_rdata(reg_rdata), .o_i2c_sda_oe(sda_oe), .o_serial_out_line(out_line),
        .o_serial_out_oe(out_oe), .o_mode(mode), .o_phy_management_mode(phy_mode),
        .o_reg_addr(reg_addr), .o_reg_wdata(reg_wdata), .o_reg_wr(reg_wr), .o_reg_rd(reg_rd));

    // ****************************************
    // tasks
    // ****************************************
    task automatic do_reset(input logic [1:0] strap);
        @(posedge i_clk);
        i_rst_b      <= 1'b0;
        i_mode_strap <= strap;
        repeat (16) @(posedge i_clk);
        i_rst_b <= 1'b1;
        repeat (4) @(posedge i_clk);
    endtask

    task automatic i2c_start;
        sda_reg <= 1'b0;
        repeat (4) @(posedge i_clk);
        scl_reg <= 1'b0;
        repeat (4) @(posedge i_clk);
    endtask

    // data moves one cycle after the clock falls so no false start is seen
    // mack is what the master puts in the ack slot: low acks a read byte
    task automatic i2c_byte(input logic [7:0] b, input logic ack, input logic mack = 1'b1);
        for (int i = 7; i >= -1; i--) begin
            sda_reg <= (i < 0) ? mack : b[i];
            repeat (4) @(posedge i_clk);
            scl_reg <= 1'b1;
            repeat (4) @(posedge i_clk);
            if (i < 0) `CHK(sda_wire, ~ack)
            else rx_byte = {rx_byte[6:0], sda_wire};
            scl_reg <= 1'b0;
            @(posedge i_clk);
        end
    endtask

    task automatic i2c_stop;
        sda_reg <= 1'b0;
        repeat (4) @(posedge i_clk);
        scl_reg <= 1'b1;
        repeat (4) @(posedge i_clk);
        sda_reg <= 1'b1;
        repeat (4) @(posedge i_clk);
    endtask

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    always @(negedge i_clk) begin
        if (out_oe === 1'b1)
            oe_seen = 1'b1;
        if (reg_wr === 1'b1) begin
            exp_note = (notes.size() != 0) ? notes.pop_front() : 24'hXXXXXX;
            `CHK({reg_addr, reg_wdata}, exp_note)
        end
    end

    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            give_verdict();
        end
    end

    // ****************************************
    // scenarios
    // ****************************************
    initial begin
        r = $urandom(32'h71AC);
        do_reset(`MODE_SPI);
        `CHK(mode, `MODE_SPI)
        `CHK(phy_mode, 1'b0)
        r = $urandom;
        host.frame(`SPI_CMD_WRITE, r[31:8], 24'h0000FF, 5);
        notes.push_back(r[23:0]);
        host.frame(`SPI_CMD_WRITE, r[31:8], {16'h0000, r[7:0]}, 8);
        r = $urandom;
        for (int k = 0; k < 3; k++)
            notes.push_back({16'hFFFE + 16'(k), r[23 - 8 * k -: 8]});
        host.frame(`SPI_CMD_WRITE, {r[31:24], 16'hFFFE}, r[23:0], 24);
        r = $urandom;
        host.frame(`SPI_CMD_READ, r[23:0], 24'h000000, 16);
        `CHK(host.rx_reg[15:0], {rdat(r[15:0]), rdat(r[15:0] + 16'h0001)})
        `CHK(oe_seen, 1'b1)
        repeat (4) @(posedge i_clk);
        oe_seen = 1'b0;
        for (int c = 0; c < 8; c++)
            if (c != 2 && c != 3)
                host.frame(3'(c), r[23:0], 24'h0000A5, 8);
        `CHK(oe_seen, 1'b0)
        i_mode_strap <= `MODE_I2C;
        repeat (8) @(posedge i_clk);
        `CHK(mode, `MODE_SPI)
        do_reset(`MODE_PHY);
        `CHK(phy_mode, 1'b1)
        host.frame(`SPI_CMD_WRITE, r[23:0], 24'h00005A, 8);
        do_reset(`MODE_I2C);
        `CHK(mode, `MODE_I2C)
        r = $urandom;
        i2c_start();
        i2c_byte(8'hBC, 1'b0);
        i2c_stop();
        i2c_start();
        i2c_byte(8'hBE, 1'b1);
        i2c_byte(r[31:24], 1'b1);
        i2c_byte(r[23:16], 1'b1);
        notes.push_back(r[31:8]);
        notes.push_back({r[31:16] + 16'h0001, r[7:0]});
        i2c_byte(r[15:8], 1'b1);
        i2c_byte(r[7:0], 1'b1);
        i2c_stop();
        i2c_start();
        i2c_byte(8'hBE, 1'b1);
        i2c_byte(r[31:24], 1'b1);
        i2c_byte(r[23:16], 1'b1);
        sda_reg <= 1'b1;
        repeat (4) @(posedge i_clk);
        scl_reg <= 1'b1;
        repeat (4) @(posedge i_clk);
        i2c_start();
        i2c_byte(8'hBF, 1'b1);
        i2c_byte(8'hFF, 1'b1, 1'b0);
        `CHK(rx_byte, rdat(r[31:16]))
        i2c_byte(8'hFF, 1'b0);
        `CHK(rx_byte, rdat(r[31:16] + 16'h0001))
        i2c_stop();
        repeat (20) @(posedge i_clk);
        `CHK(notes.size(), 0)
        give_verdict();
    end
endmodule // tb
